// *** rtl/ccrf_pkg.sv ***
// Package: constants and types for the CPU core register file and flags
package ccrf_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	// Condition-code bit positions
	localparam int CC_CARRY_BIT  = 0;
	localparam int CC_ZERO_BIT   = 1;
	localparam int CC_NEG_BIT    = 2;
	localparam int CC_PRIO_LO    = 3;
	localparam int CC_HALF_BIT   = 4;
	localparam int CC_PRIO_HI    = 5;
	// Undefined bits of the reset pattern are given zero here
	localparam logic [7:0]  CC_RESET     = 8'he8;
	localparam logic [15:0] SP_RESET     = 16'h01ff;
	localparam logic [7:0]  SP_PAGE      = 8'h01;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	// Priority encodings {high,low}
	localparam logic [1:0] PRIO_LVL0 = 2'b10;
	localparam logic [1:0] PRIO_LVL1 = 2'b01;
	localparam logic [1:0] PRIO_LVL2 = 2'b00;
	localparam logic [1:0] PRIO_LVL3 = 2'b11;
	// Register selectors for the write port
	typedef enum logic [2:0] {
		CCRF_SEL_NONE = 3'h0,
		CCRF_SEL_ACC  = 3'h1,
		CCRF_SEL_IDX  = 3'h3,
		CCRF_SEL_PCL  = 3'h2,
		CCRF_SEL_PCH  = 3'h6,
		CCRF_SEL_CC   = 3'h7,
		CCRF_SEL_SPL  = 3'h5
	} ccrf_sel_t;
	// ALU operation classes; all but CCRF_OP_NONE update flags
	typedef enum logic [2:0] {
		CCRF_OP_NONE  = 3'h0,
		CCRF_OP_ADD   = 3'h1,
		CCRF_OP_ADC   = 3'h3,
		CCRF_OP_SUB   = 3'h2,
		CCRF_OP_LOGIC = 3'h6,
		CCRF_OP_SHIFT = 3'h7
	} ccrf_op_t;
endpackage : ccrf_pkg

// *** rtl/ccrf_flags.sv ***
// Flag computation for one ALU result
`timescale 1ns/10ps
module ccrf_flags (
	input  wire logic               MCLK_IN,
	input  wire logic               RST_B_IN,
	input  wire ccrf_pkg::ccrf_op_t op_in,
	input  wire logic [7:0]         a_in,
	input  wire logic [7:0]         b_in,
	input  wire logic               carry_in,
	input  wire logic               shift_carry_in,
	output logic      [7:0]         result_out,
	output logic                    half_out,
	output logic                    neg_out,
	output logic                    zero_out,
	output logic                    carry_out
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic       cin;

	always_comb begin
		cin = (op_in == ccrf_pkg::CCRF_OP_ADC) ? carry_in : 1'b0;
		low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
		case (op_in)
			ccrf_pkg::CCRF_OP_ADD,
			ccrf_pkg::CCRF_OP_ADC: begin
				sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
			end
			ccrf_pkg::CCRF_OP_SUB: begin
				sum = {1'b0, a_in} - {1'b0, b_in};
			end
			ccrf_pkg::CCRF_OP_SHIFT: begin
				sum = {a_in[7], a_in[6:0], 1'b0};
			end
			default: begin
				sum = {1'b0, b_in};
			end
		endcase
		result_out = sum[7:0];
		half_out   = low_sum[4];
		neg_out    = sum[7];
		zero_out   = (sum[7:0] == 8'h00);
		carry_out  = (op_in == ccrf_pkg::CCRF_OP_SHIFT) ? shift_carry_in
			: sum[8];
	end
endmodule : ccrf_flags

// *** rtl/ccrf_core_regs.sv ***
// CPU core programmer-visible registers and condition-code flags
//
// Summary of operation
// - Six internal registers, instruction access only
// - 8-bit accumulator takes ALU operands, results
// - Two 8-bit index registers
// - Prefix makes next instruction use second index
// - Interrupt context save skips second index
// - 16-bit program counter from low, high bytes
// - Condition-code resets with bits 7,6,5,3 set
// - Condition code pushed, popped, bits altered
// - Half carry from bit 3 on add
// - Negative flag copies result bit 7
// - Zero flag set on zero result
// - Carry flag marks overflow or underflow
// - Carry set, reset, shift, bit-test update
// - Priority bits 5,3 encode levels 0..3
// - Interrupt entry loads priority from source
// - Priority writable by several instructions
// - Stack pointer upper byte fixed, resets 01FF
`timescale 1ns/10ps
module ccrf_core_regs (
	input  wire logic                MCLK_IN,
	input  wire logic                RST_B_IN,
	input  wire ccrf_pkg::ccrf_op_t  ALU_OP_IN,
	input  wire logic [7:0]          ALU_B_IN,
	input  wire logic                ALU_IDX_DEST_IN,
	input  wire logic                SHIFT_CARRY_IN,
	input  wire logic                PREFIX_IN,
	input  wire logic                INSTR_DONE_IN,
	input  wire ccrf_pkg::ccrf_sel_t WR_SEL_IN,
	input  wire logic [7:0]          WR_DATA_IN,
	input  wire logic                SET_CARRY_INSTR_IN,
	input  wire logic                RESET_CARRY_INSTR_IN,
	input  wire logic                BIT_TEST_IN,
	input  wire logic                BIT_TEST_CARRY_IN,
	input  wire logic                PRIO_WR_IN,
	input  wire logic [1:0]          PRIO_DATA_IN,
	input  wire logic                IRQ_ENTRY_IN,
	input  wire logic [1:0]          IRQ_SPR_BITS_IN,
	input  wire logic                IRQ_RETURN_IN,
	input  wire logic [7:0]          CTX_CC_IN,
	input  wire logic [7:0]          CTX_ACC_IN,
	input  wire logic [7:0]          CTX_IDX_IN,
	input  wire logic [15:0]         CTX_PC_IN,
	input  wire logic                PC_LOAD_IN,
	input  wire logic [15:0]         PC_LOAD_DATA_IN,
	input  wire logic                PC_INC_IN,
	input  wire logic                SP_PUSH_IN,
	input  wire logic                SP_POP_IN,
	input  wire logic                RESET_SP_INSTR_IN,
	output logic      [7:0]          ACC_OUT,
	output logic      [7:0]          INDEX_X_OUT,
	output logic      [7:0]          INDEX_Y_OUT,
	output logic      [7:0]          INDEX_SEL_OUT,
	output logic      [15:0]         PROGRAM_COUNTER_OUT,
	output logic      [7:0]          CONDITION_CODE_FLAGS_OUT,
	output logic      [15:0]         STACK_POINTER_OUT,
	output logic      [1:0]          PRIO_LEVEL_OUT
);
	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idx_x;
		logic [7:0]  idx_y;
		logic [15:0] pc;
		logic [7:0]  cc;
		logic [7:0]  sp_low;
		logic        use_y;
	} ccrf_state_t;

	ccrf_state_t st_r;
	ccrf_state_t st_nxt;

	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic       f_half;
	logic       f_neg;
	logic       f_zero;
	logic       f_carry;
	logic       is_add;

	// Level 3 means interrupts off; map encoding to level number
	function automatic logic [1:0] prio_level(input logic [1:0] enc);
		case (enc)
			ccrf_pkg::PRIO_LVL0: prio_level = 2'h0;
			ccrf_pkg::PRIO_LVL1: prio_level = 2'h1;
			ccrf_pkg::PRIO_LVL2: prio_level = 2'h2;
			default:             prio_level = 2'h3;
		endcase
	endfunction : prio_level

	function automatic logic [7:0] put_prio(input logic [7:0] cc,
		input logic [1:0] enc);
		logic [7:0] r;
		r = cc;
		r[ccrf_pkg::CC_PRIO_HI] = enc[1];
		r[ccrf_pkg::CC_PRIO_LO] = enc[0];
		put_prio = r;
	endfunction : put_prio

	assign alu_a = ALU_IDX_DEST_IN
		? (st_r.use_y ? st_r.idx_y : st_r.idx_x) : st_r.acc;
	assign is_add = (ALU_OP_IN == ccrf_pkg::CCRF_OP_ADD)
		|| (ALU_OP_IN == ccrf_pkg::CCRF_OP_ADC);

	ccrf_flags u_flags (
		.MCLK_IN        (MCLK_IN),
		.RST_B_IN       (RST_B_IN),
		.op_in          (ALU_OP_IN),
		.a_in           (alu_a),
		.b_in           (ALU_B_IN),
		.carry_in       (st_r.cc[ccrf_pkg::CC_CARRY_BIT]),
		.shift_carry_in (SHIFT_CARRY_IN),
		.result_out     (alu_res),
		.half_out       (f_half),
		.neg_out        (f_neg),
		.zero_out       (f_zero),
		.carry_out      (f_carry)
	);

	always_comb begin
		st_nxt = st_r;
		// Prefix applies to exactly the next instruction
		if (PREFIX_IN) begin
			st_nxt.use_y = 1'b1;
		end else if (INSTR_DONE_IN) begin
			st_nxt.use_y = 1'b0;
		end
		// Result flags and destination of an ALU operation
		if (ALU_OP_IN != ccrf_pkg::CCRF_OP_NONE) begin
			if (ALU_IDX_DEST_IN && st_r.use_y) begin
				st_nxt.idx_y = alu_res;
			end else if (ALU_IDX_DEST_IN) begin
				st_nxt.idx_x = alu_res;
			end else begin
				st_nxt.acc = alu_res;
			end
			st_nxt.cc[ccrf_pkg::CC_NEG_BIT]  = f_neg;
			st_nxt.cc[ccrf_pkg::CC_ZERO_BIT] = f_zero;
			if (is_add) begin
				st_nxt.cc[ccrf_pkg::CC_HALF_BIT] = f_half;
			end
			if (ALU_OP_IN != ccrf_pkg::CCRF_OP_LOGIC) begin
				st_nxt.cc[ccrf_pkg::CC_CARRY_BIT] = f_carry;
			end
		end
		if (BIT_TEST_IN) begin
			st_nxt.cc[ccrf_pkg::CC_CARRY_BIT] = BIT_TEST_CARRY_IN;
		end
		if (SET_CARRY_INSTR_IN) begin
			st_nxt.cc[ccrf_pkg::CC_CARRY_BIT] = 1'b1;
		end else if (RESET_CARRY_INSTR_IN) begin
			st_nxt.cc[ccrf_pkg::CC_CARRY_BIT] = 1'b0;
		end
		// Direct register writes, index write follows the prefix
		case (WR_SEL_IN)
			ccrf_pkg::CCRF_SEL_ACC: st_nxt.acc = WR_DATA_IN;
			ccrf_pkg::CCRF_SEL_IDX: begin
				if (st_r.use_y) begin
					st_nxt.idx_y = WR_DATA_IN;
				end else begin
					st_nxt.idx_x = WR_DATA_IN;
				end
			end
			ccrf_pkg::CCRF_SEL_PCL: st_nxt.pc[7:0] = WR_DATA_IN;
			ccrf_pkg::CCRF_SEL_PCH: st_nxt.pc[15:8] = WR_DATA_IN;
			ccrf_pkg::CCRF_SEL_CC:  st_nxt.cc = WR_DATA_IN;
			ccrf_pkg::CCRF_SEL_SPL: st_nxt.sp_low = WR_DATA_IN;
			default: begin
			end
		endcase
		if (PC_LOAD_IN) begin
			st_nxt.pc = PC_LOAD_DATA_IN;
		end else if (PC_INC_IN) begin
			st_nxt.pc = st_r.pc + 16'h0001;
		end
		// Stack wraps inside its page without warning
		if (RESET_SP_INSTR_IN) begin
			st_nxt.sp_low = ccrf_pkg::SP_RESET[7:0];
		end else if (SP_PUSH_IN && !SP_POP_IN) begin
			st_nxt.sp_low = st_r.sp_low - 8'h01;
		end else if (SP_POP_IN && !SP_PUSH_IN) begin
			st_nxt.sp_low = st_r.sp_low + 8'h01;
		end
		if (PRIO_WR_IN) begin
			st_nxt.cc = put_prio(st_nxt.cc, PRIO_DATA_IN);
		end
		// Return restores context but never the second index
		if (IRQ_RETURN_IN) begin
			st_nxt.cc    = CTX_CC_IN;
			st_nxt.acc   = CTX_ACC_IN;
			st_nxt.idx_x = CTX_IDX_IN;
			st_nxt.pc    = CTX_PC_IN;
		end
		// Entry has the last word on priority
		if (IRQ_ENTRY_IN) begin
			st_nxt.cc = put_prio(st_nxt.cc, IRQ_SPR_BITS_IN);
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			st_r.acc    <= ccrf_pkg::REG_RESET;
			st_r.idx_x  <= ccrf_pkg::REG_RESET;
			st_r.idx_y  <= ccrf_pkg::REG_RESET;
			st_r.pc     <= ccrf_pkg::PC_RESET;
			st_r.cc     <= ccrf_pkg::CC_RESET;
			st_r.sp_low <= ccrf_pkg::SP_RESET[7:0];
			st_r.use_y  <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ACC_OUT                  = st_r.acc;
	assign INDEX_X_OUT              = st_r.idx_x;
	assign INDEX_Y_OUT              = st_r.idx_y;
	assign INDEX_SEL_OUT            = st_r.use_y ? st_r.idx_y : st_r.idx_x;
	assign PROGRAM_COUNTER_OUT      = st_r.pc;
	assign CONDITION_CODE_FLAGS_OUT = st_r.cc;
	assign STACK_POINTER_OUT        = {ccrf_pkg::SP_PAGE, st_r.sp_low};
	assign PRIO_LEVEL_OUT = prio_level({st_r.cc[ccrf_pkg::CC_PRIO_HI],
		st_r.cc[ccrf_pkg::CC_PRIO_LO]});

	a_cc_reset: assert property (@(posedge MCLK_IN)
		$rose(RST_B_IN) |-> (st_r.cc[7:5] == 3'h7 && st_r.cc[3]))
		else $error("cc reset pattern wrong");
	a_sp_page: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		STACK_POINTER_OUT[15:8] == ccrf_pkg::SP_PAGE)
		else $error("stack page not fixed");
	a_rsp_value: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		RESET_SP_INSTR_IN |=> STACK_POINTER_OUT == ccrf_pkg::SP_RESET)
		else $error("stack reset value wrong");
	a_y_ctx_kept: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(IRQ_RETURN_IN && WR_SEL_IN == ccrf_pkg::CCRF_SEL_NONE
		&& ALU_OP_IN == ccrf_pkg::CCRF_OP_NONE) |=> $stable(st_r.idx_y))
		else $error("second index changed by return");
	a_irq_prio: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		IRQ_ENTRY_IN |=> {CONDITION_CODE_FLAGS_OUT[5],
		CONDITION_CODE_FLAGS_OUT[3]} == $past(IRQ_SPR_BITS_IN))
		else $error("priority not loaded on entry");
	a_zero_flag: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(ALU_OP_IN != ccrf_pkg::CCRF_OP_NONE && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> CONDITION_CODE_FLAGS_OUT[1] == ($past(alu_res) == 8'h00))
		else $error("zero flag mismatch");
	a_neg_flag: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(ALU_OP_IN != ccrf_pkg::CCRF_OP_NONE && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> CONDITION_CODE_FLAGS_OUT[2] == $past(alu_res[7]))
		else $error("negative flag mismatch");
	a_scf_carry: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(SET_CARRY_INSTR_IN && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> CONDITION_CODE_FLAGS_OUT[0])
		else $error("carry not set");
	a_prefix_y: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		PREFIX_IN |=> INDEX_SEL_OUT == INDEX_Y_OUT)
		else $error("prefix did not select second index");
	a_half_flag: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(is_add && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> CONDITION_CODE_FLAGS_OUT[4] == $past(f_half))
		else $error("half carry flag mismatch");
	a_add_carry: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(is_add && !BIT_TEST_IN && !SET_CARRY_INSTR_IN
		&& !RESET_CARRY_INSTR_IN && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> CONDITION_CODE_FLAGS_OUT[0] == $past(f_carry))
		else $error("carry flag mismatch");
	a_rcf_carry: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(RESET_CARRY_INSTR_IN && !SET_CARRY_INSTR_IN && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_CC)
		|=> !CONDITION_CODE_FLAGS_OUT[0])
		else $error("carry not cleared");
	a_pc_step: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(PC_INC_IN && !PC_LOAD_IN && !IRQ_RETURN_IN
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_PCL
		&& WR_SEL_IN != ccrf_pkg::CCRF_SEL_PCH)
		|=> PROGRAM_COUNTER_OUT == $past(PROGRAM_COUNTER_OUT) + 16'h0001)
		else $error("program counter did not step");
	a_prio_write: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(PRIO_WR_IN && !IRQ_RETURN_IN && !IRQ_ENTRY_IN)
		|=> {CONDITION_CODE_FLAGS_OUT[5],
		CONDITION_CODE_FLAGS_OUT[3]} == $past(PRIO_DATA_IN))
		else $error("priority write lost");
	a_y_write: assert property (@(posedge MCLK_IN)
		disable iff (!RST_B_IN)
		(WR_SEL_IN == ccrf_pkg::CCRF_SEL_IDX && st_r.use_y)
		|=> INDEX_Y_OUT == $past(WR_DATA_IN))
		else $error("prefixed write missed second index");
	c_irq_entry: cover property (@(posedge MCLK_IN) IRQ_ENTRY_IN);
	c_irq_return: cover property (@(posedge MCLK_IN) IRQ_RETURN_IN);
	c_pc_load: cover property (@(posedge MCLK_IN) PC_LOAD_IN);
	c_prefix_use: cover property (@(posedge MCLK_IN)
		PREFIX_IN ##1 WR_SEL_IN == ccrf_pkg::CCRF_SEL_IDX);
	c_add_half: cover property (@(posedge MCLK_IN) is_add && f_half);
endmodule : ccrf_core_regs

// *** verification/tb_top.sv ***
// Self-checking bench for the core register file and condition-code flags
`timescale 1ns/10ps
module tb_top;
	logic                mclk, rst_b;
	ccrf_pkg::ccrf_op_t  op;
	ccrf_pkg::ccrf_sel_t sel;
	logic [7:0]          b, wd, ccc, cac, cix;
	logic [15:0]         pld, cpc;
	logic                idx, sc, pre, done, set_carry_instr, reset_carry_instr, bt, btc, pw;
	logic                ie, ir, pl, pi, psh, pop, rsp;
	logic [1:0]          pd, spr;
	logic [7:0]          acc, ix, iy, isel, cc;
	logic [15:0]         pc, sp;
	logic [1:0]          lvl;
	int                  mismatches, comparisons;
	int                  cycles = 0;

	ccrf_core_regs dut_u (.MCLK_IN(mclk), .RST_B_IN(rst_b), .ALU_OP_IN(op),
		.ALU_B_IN(b), .ALU_IDX_DEST_IN(idx), .SHIFT_CARRY_IN(sc),
		.PREFIX_IN(pre), .INSTR_DONE_IN(done), .WR_SEL_IN(sel),
		.WR_DATA_IN(wd), .SET_CARRY_INSTR_IN(set_carry_instr), .RESET_CARRY_INSTR_IN(reset_carry_instr),
		.BIT_TEST_IN(bt), .BIT_TEST_CARRY_IN(btc), .PRIO_WR_IN(pw),
		.PRIO_DATA_IN(pd), .IRQ_ENTRY_IN(ie), .IRQ_SPR_BITS_IN(spr),
		.IRQ_RETURN_IN(ir), .CTX_CC_IN(ccc), .CTX_ACC_IN(cac),
		.CTX_IDX_IN(cix), .CTX_PC_IN(cpc), .PC_LOAD_IN(pl),
		.PC_LOAD_DATA_IN(pld), .PC_INC_IN(pi), .SP_PUSH_IN(psh),
		.SP_POP_IN(pop), .RESET_SP_INSTR_IN(rsp), .ACC_OUT(acc),
		.INDEX_X_OUT(ix), .INDEX_Y_OUT(iy), .INDEX_SEL_OUT(isel),
		.PROGRAM_COUNTER_OUT(pc), .CONDITION_CODE_FLAGS_OUT(cc),
		.STACK_POINTER_OUT(sp), .PRIO_LEVEL_OUT(lvl));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Context inputs are parked on the acc, index and PC values that t_ctx expects; only the cc value differs
	task automatic idle();
		op <= ccrf_pkg::CCRF_OP_NONE;
		sel <= ccrf_pkg::CCRF_SEL_NONE;
		{b, wd, idx, sc, pre, done, set_carry_instr, reset_carry_instr, bt, btc} <= '0;
		{pw, pd, ie, spr, ir, pl, pld, pi, psh, pop, rsp} <= '0;
		{ccc, cac, cix, cpc} <= {8'h2a, 8'h3c, 8'h5a, 16'h4321};
	endtask : idle

	// Inputs were set at the previous edge; this edge takes them
	task automatic fin();
		@(posedge mclk);
		idle();
		#1;
	endtask : fin

	task automatic wr(input ccrf_pkg::ccrf_sel_t s, input logic [7:0] d);
		@(posedge mclk);
		sel <= s;
		wd <= d;
		fin();
	endtask : wr

	task automatic alu(input ccrf_pkg::ccrf_op_t o, input logic [7:0] v,
		input logic i, input logic c);
		@(posedge mclk);
		op <= o;
		b <= v;
		idx <= i;
		sc <= c;
		fin();
	endtask : alu

	task automatic t_reset();
		chk({acc, ix}, 16'h0000);
		chk({iy, cc}, 16'h00e8);
		chk(pc, 16'h0000);
		chk(sp, 16'h01ff);
		chk(lvl, 2'd3);
	endtask : t_reset

	task automatic t_arith();
		wr(ccrf_pkg::CCRF_SEL_ACC, 8'h0f);
		alu(ccrf_pkg::CCRF_OP_ADD, 8'h01, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'h1008);
		alu(ccrf_pkg::CCRF_OP_ADD, 8'hf0, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'h0003);
		alu(ccrf_pkg::CCRF_OP_ADC, 8'h7f, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'h800c);
		alu(ccrf_pkg::CCRF_OP_SUB, 8'h81, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'hff0d);
		// Logic ops leave carry and half alone
		alu(ccrf_pkg::CCRF_OP_LOGIC, 8'h00, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'h000b);
		wr(ccrf_pkg::CCRF_SEL_ACC, 8'h81);
		alu(ccrf_pkg::CCRF_OP_SHIFT, 8'h00, 1'b0, 1'b0);
		chk({acc, 4'h0, cc[4], cc[2:0]}, 16'h0208);
	endtask : t_arith

	task automatic t_carry();
		@(posedge mclk);
		set_carry_instr <= 1'b1;
		fin();
		chk(cc[0], 1'b1);
		@(posedge mclk);
		reset_carry_instr <= 1'b1;
		fin();
		chk(cc[0], 1'b0);
		@(posedge mclk);
		{set_carry_instr, reset_carry_instr} <= 2'b11;
		fin();
		chk(cc[0], 1'b1);
		@(posedge mclk);
		bt <= 1'b1;
		fin();
		chk(cc[0], 1'b0);
	endtask : t_carry

	task automatic t_index();
		alu(ccrf_pkg::CCRF_OP_LOGIC, 8'h55, 1'b1, 1'b0);
		chk({ix, isel}, 16'h5555);
		@(posedge mclk);
		pre <= 1'b1;
		fin();
		alu(ccrf_pkg::CCRF_OP_LOGIC, 8'haa, 1'b1, 1'b0);
		chk({ix, iy}, 16'h55aa);
		chk(isel, 8'haa);
		wr(ccrf_pkg::CCRF_SEL_IDX, 8'h66);
		chk({ix, iy}, 16'h5566);
		@(posedge mclk);
		done <= 1'b1;
		fin();
		chk(isel, 8'h55);
	endtask : t_index

	task automatic t_pc();
		@(posedge mclk);
		pl <= 1'b1;
		pld <= 16'h1234;
		fin();
		chk(pc, 16'h1234);
		@(posedge mclk);
		pi <= 1'b1;
		fin();
		chk(pc, 16'h1235);
		wr(ccrf_pkg::CCRF_SEL_PCL, 8'hab);
		wr(ccrf_pkg::CCRF_SEL_PCH, 8'hcd);
		chk(pc, 16'hcdab);
	endtask : t_pc

	task automatic t_sp();
		@(posedge mclk);
		psh <= 1'b1;
		fin();
		chk(sp, 16'h01fe);
		repeat (2) begin
			@(posedge mclk);
			pop <= 1'b1;
			fin();
		end
		// Upper byte is fixed, so an overflow wraps inside the page
		chk(sp, 16'h0100);
		@(posedge mclk);
		rsp <= 1'b1;
		fin();
		chk(sp, 16'h01ff);
		wr(ccrf_pkg::CCRF_SEL_SPL, 8'h40);
		chk(sp, 16'h0140);
	endtask : t_sp

	task automatic t_prio();
		logic [1:0] enc [4];
		enc = '{2'b10, 2'b01, 2'b00, 2'b11};
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			pw <= 1'b1;
			pd <= enc[i];
			fin();
			chk({lvl, cc[5], cc[3]}, {2'(i), enc[i]});
		end
		@(posedge mclk);
		ie <= 1'b1;
		spr <= 2'b01;
		fin();
		chk({lvl, cc[5], cc[3]}, 4'b0101);
		wr(ccrf_pkg::CCRF_SEL_CC, 8'hc3);
		chk({cc, 6'h00, lvl}, 16'hc302);
	endtask : t_prio

	task automatic t_ctx();
		@(posedge mclk);
		ir <= 1'b1;
		ccc <= 8'he1;
		cac <= 8'h3c;
		cix <= 8'h5a;
		cpc <= 16'h4321;
		fin();
		chk({cc, acc}, 16'he13c);
		chk({ix, iy}, 16'h5a66);
		chk({pc, lvl}, {16'h4321, 2'd0});
	endtask : t_ctx

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Ceiling is over ten times the length of the whole sequence
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			mismatches++;
			summarize();
		end
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		rst_b = 1'b0;
		idle();
		repeat (10) @(posedge mclk);
		#1;
		t_reset();
		@(posedge mclk);
		rst_b <= 1'b1;
		t_arith();
		t_carry();
		t_index();
		t_pc();
		t_sp();
		t_prio();
		t_ctx();
		summarize();
	end
endmodule : tb_top
